// [logic/thic_defs.vh]
// Constants of the limit and alert configuration block.
// Assumes inclusion by bare name from the design files under logic/.
`ifndef THIC_DEFS_VH
`define THIC_DEFS_VH

`define THIC_OFF_PLANAR1  8'h04
`define THIC_OFF_PLANAR2  8'h05
`define THIC_OFF_VERT     8'h06
`define THIC_OFF_TEMP     8'h07
`define THIC_OFF_ALERT    8'h08
`define THIC_OFF_GAIN     8'h09
`define THIC_RST_VAL      8'h00

`define THIC_TEMP_ACQ_BIT 0
`define THIC_DONE_EN_BIT  7
`define THIC_LIMIT_EN_BIT 6
`define THIC_PULSE_BIT    5
`define THIC_ROUTE_HI     4
`define THIC_ROUTE_LO     2
`define THIC_RSVD_BIT     1
`define THIC_PIN_DIS_BIT  0
`define THIC_ALERT_WMASK  8'hFD

`define THIC_ROUTE_NONE   3'h0
`define THIC_ROUTE_PIN    3'h1
`define THIC_ROUTE_PIN_NB 3'h2
`define THIC_ROUTE_SCL    3'h3
`define THIC_ROUTE_SCL_NB 3'h4

`define THIC_HYST_DIR_MAX 3'h1
`define THIC_UNITY_GAIN   9'h100
`define THIC_CLK_NS       25
`define THIC_PULSE_NS     10000
`define THIC_PULSE_CYC    (`THIC_PULSE_NS / `THIC_CLK_NS)
`define THIC_DEV_ADDR     7'h35

`endif

// [logic/thic_i2c_target.v]
// Serial register-access target: byte-wide pointer, auto-increment.
// Assumes raw bus pins sampled by the local clock, far faster than the bus.
`timescale 1ns/1ps
`include "thic_defs.vh"
module thic_i2c_target #(
   parameter [6:0] DEV_ADDR = `THIC_DEV_ADDR
) (
   input  wire       ref_clk_i,
   input  wire       rstn_i,
   input  wire       scl_i,
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe_o,
   input  wire [7:0] rdata_i,
   output wire [7:0] addr_o,
   output wire [7:0] wdata_o,
   output wire       wr_stb_o,
   output wire       addressed_o,
   output wire       busy_o
);
   localparam [6:0] ST_IDLE = 7'b0000001;
   localparam [6:0] ST_ADDR = 7'b0000010;
   localparam [6:0] ST_AACK = 7'b0000100;
   localparam [6:0] ST_WR   = 7'b0001000;
   localparam [6:0] ST_WACK = 7'b0010000;
   localparam [6:0] ST_RD   = 7'b0100000;
   localparam [6:0] ST_RACK = 7'b1000000;

   reg [2:0] scl_sync_ff;
   reg [2:0] sda_sync_ff;
   reg [6:0] state_ff;
   reg [2:0] bit_cnt_ff;
   reg       got_ff;
   reg [7:0] shift_ff;
   reg [7:0] ptr_ff;
   reg       first_ff;
   reg       rw_ff;
   reg       acked_ff;
   reg       drive_ff;
   reg       busy_ff;
   reg       wr_stb_ff;
   reg       addressed_ff;
   reg [7:0] wdata_ff;
   reg [7:0] waddr_ff;

   wire scl_rise = scl_sync_ff[1] & ~scl_sync_ff[2];
   wire scl_fall = ~scl_sync_ff[1] & scl_sync_ff[2];
   wire sda_now  = sda_sync_ff[1];
   wire start_c  = scl_sync_ff[1] & ~sda_sync_ff[1] & sda_sync_ff[2];
   wire stop_c   = scl_sync_ff[1] & sda_sync_ff[1] & ~sda_sync_ff[2];

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_sync_ff <= 3'h7;
         sda_sync_ff <= 3'h7;
      end else begin
         scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
         sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      end
   end

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_ff     <= ST_IDLE;
         bit_cnt_ff   <= 3'h0;
         got_ff       <= 1'b0;
         shift_ff     <= 8'h00;
         ptr_ff       <= 8'h00;
         first_ff     <= 1'b0;
         rw_ff        <= 1'b0;
         acked_ff     <= 1'b0;
         drive_ff     <= 1'b0;
         busy_ff      <= 1'b0;
         wr_stb_ff    <= 1'b0;
         addressed_ff <= 1'b0;
         wdata_ff     <= 8'h00;
         waddr_ff     <= 8'h00;
      end else begin
         wr_stb_ff    <= 1'b0;
         addressed_ff <= 1'b0;
         if (start_c) begin
            state_ff   <= ST_ADDR;
            bit_cnt_ff <= 3'h0;
            got_ff     <= 1'b0;
            drive_ff   <= 1'b0;
            busy_ff    <= 1'b1;
         end else if (stop_c) begin
            state_ff <= ST_IDLE;
            drive_ff <= 1'b0;
            busy_ff  <= 1'b0;
         end else begin
            case (state_ff)
               ST_ADDR, ST_WR: begin
                  if (scl_rise) begin
                     shift_ff   <= {shift_ff[6:0], sda_now};
                     bit_cnt_ff <= bit_cnt_ff + 3'h1;
                     got_ff     <= (bit_cnt_ff == 3'h7);
                  end else if (scl_fall && got_ff) begin
                     got_ff <= 1'b0;
                     if (state_ff == ST_ADDR) begin
                        if (shift_ff[7:1] == DEV_ADDR) begin
                           state_ff     <= ST_AACK;
                           drive_ff     <= 1'b1;
                           rw_ff        <= shift_ff[0];
                           addressed_ff <= 1'b1;
                        end else begin
                           state_ff <= ST_IDLE;
                        end
                     end else begin
                        state_ff <= ST_WACK;
                        drive_ff <= 1'b1;
                        if (first_ff) begin
                           ptr_ff   <= shift_ff;
                           first_ff <= 1'b0;
                        end else begin
                           waddr_ff  <= ptr_ff;
                           wdata_ff  <= shift_ff;
                           wr_stb_ff <= 1'b1;
                           ptr_ff    <= ptr_ff + 8'h01;
                        end
                     end
                  end
               end
               ST_AACK, ST_WACK: begin
                  if (scl_fall) begin
                     bit_cnt_ff <= 3'h0;
                     if (state_ff == ST_AACK && rw_ff) begin
                        state_ff <= ST_RD;
                        shift_ff <= rdata_i;
                        drive_ff <= ~rdata_i[7];
                        ptr_ff   <= ptr_ff + 8'h01;
                     end else begin
                        state_ff <= ST_WR;
                        drive_ff <= 1'b0;
                        if (state_ff == ST_AACK) begin
                           first_ff <= 1'b1;
                        end
                     end
                  end
               end
               ST_RD: begin
                  if (scl_rise) begin
                     bit_cnt_ff <= bit_cnt_ff + 3'h1;
                     got_ff     <= (bit_cnt_ff == 3'h7);
                  end else if (scl_fall) begin
                     if (got_ff) begin
                        got_ff   <= 1'b0;
                        drive_ff <= 1'b0;
                        state_ff <= ST_RACK;
                     end else begin
                        shift_ff <= {shift_ff[6:0], 1'b0};
                        drive_ff <= ~shift_ff[6];
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     acked_ff <= ~sda_now;
                  end else if (scl_fall) begin
                     if (acked_ff) begin
                        state_ff   <= ST_RD;
                        bit_cnt_ff <= 3'h0;
                        shift_ff   <= rdata_i;
                        drive_ff   <= ~rdata_i[7];
                        ptr_ff     <= ptr_ff + 8'h01;
                     end else begin
                        state_ff <= ST_IDLE;
                     end
                  end
               end
               ST_IDLE: begin
                  drive_ff <= 1'b0;
               end
               default: begin
                  state_ff <= ST_IDLE;
                  drive_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   assign sda_o       = 1'b0;
   assign sda_oe_o    = drive_ff;
   assign addr_o      = (wr_stb_ff) ? waddr_ff : ptr_ff;
   assign wdata_o     = wdata_ff;
   assign wr_stb_o    = wr_stb_ff;
   assign addressed_o = addressed_ff;
   assign busy_o      = busy_ff;
endmodule

// [logic/thic_limit_alert.v]
// Limit-check and alert configuration block of a 3-axis field sensor.
// Assumes conversion results and done pulses arrive on ref_clk_i; the
// serial bus and the alert pin are asynchronous and synchronised here.
//
// Functional notes
// RQ1: First planar limit is signed 8-bit; zero code disables its check.
// RQ2: Second planar limit is signed 8-bit; zero code disables its check.
// RQ3: Vertical limit is signed 8-bit; zero code disables its check.
// RQ4: Planar step is base scale times one plus span bit over 128.
// RQ5: Vertical step is base scale times one plus span bit over 128.
// RQ6: Temperature limit is 7-bit code, 8 C per step, zero disables.
// RQ7: Temperature setup bit 0 turns temperature acquisition on.
// RQ8: Alert setup bit 7 enables alert on conversion set done.
// RQ9: Alert setup bit 6 enables alert on limit crossing.
// RQ10: Bit 5 low latches alert until addressed; high gives 10 us pulse.
// RQ11: Route field picks none, pin, pin-unless-busy, clock line, or variant.
// RQ12: Alert setup bit 0 disables pin for wake-up and trigger use.
// RQ13: Gain value is value/256; zero means unity gain.
// RQ14: Gain goes to axis picked by gain select and axis-pair field.
// RQ15: Limit alert after one crossing, or four when count select is set.
// RQ16: Direction bit picks above or below; ignored when hysteresis over 1.
// RQ17: Gain select low picks first axis of pair, high picks second.
// RQ18: Limits compare against upper eight bits of each conversion result.
// RQ19: The 10 us pulse is timed by counting internal clock cycles.
`timescale 1ns/1ps
`include "thic_defs.vh"
module thic_limit_alert #(
   parameter [6:0] DEV_ADDR   = `THIC_DEV_ADDR,
   parameter       PULSE_CYC  = `THIC_PULSE_CYC
) (
   input  wire       ref_clk_i,
   input  wire       rstn_i,
   input  wire       scl_i,
   output wire       scl_o,
   output wire       scl_oe_o,
   input  wire       sda_i,
   output wire       sda_o,
   output wire       sda_oe_o,
   input  wire       alert_pin_i,
   output wire       alert_pin_o,
   output wire       alert_pin_oe_o,
   input  wire       conv_done_i,
   input  wire [7:0] planar_first_msb_i,
   input  wire [7:0] planar_second_msb_i,
   input  wire [7:0] vertical_msb_i,
   input  wire [6:0] temperature_code_i,
   input  wire       crossing_count_select_i,
   input  wire       limit_direction_i,
   input  wire [2:0] hysteresis_i,
   input  wire       gain_axis_pick_i,
   input  wire [1:0] angle_pair_i,
   output wire       temperature_acquire_on_o,
   output wire       pin_trigger_o,
   output wire [8:0] gain_factor_o,
   output wire [1:0] gain_axis_o,
   output wire       alert_o
);
   reg  [7:0] planar_first_limit_code_ff;
   reg  [7:0] planar_second_limit_code_ff;
   reg  [7:0] vertical_limit_code_ff;
   reg  [7:0] temperature_setup_ff;
   reg  [7:0] alert_setup_ff;
   reg  [7:0] gain_correction_reg_ff;
   reg  [1:0] cross_cnt_ff;
   reg  [1:0] nxt_cross_cnt;
   reg        latched_ff;
   reg [15:0] pulse_cnt_ff;
   reg        pin_oe_ff;
   reg        scl_drv_ff;
   reg  [2:0] pin_sync_ff;
   reg        trig_ff;
   reg  [8:0] gain_factor_ff;
   reg  [1:0] gain_axis_ff;
   reg  [7:0] rdata;
   reg        limit_fire;

   wire [7:0] reg_addr;
   wire [7:0] reg_wdata;
   wire       reg_wr;
   wire       addressed;
   wire       bus_busy;

   wire       done_alert_on  = alert_setup_ff[`THIC_DONE_EN_BIT];
   wire       limit_alert_on = alert_setup_ff[`THIC_LIMIT_EN_BIT];
   wire       pulse_mode     = alert_setup_ff[`THIC_PULSE_BIT];
   wire [2:0] route = alert_setup_ff[`THIC_ROUTE_HI:`THIC_ROUTE_LO];
   wire       alert_pin_disable = alert_setup_ff[`THIC_PIN_DIS_BIT];
   wire [6:0] temperature_limit_code = temperature_setup_ff[7:1];

   // Signed check of one axis; a zero limit never fires.
   function limit_hit;
      input [7:0] value;
      input [7:0] limit;
      input       below;
      begin
         if (limit == 8'h00) begin
            limit_hit = 1'b0;
         end else if (below) begin
            limit_hit = ($signed(value) < $signed(limit));
         end else begin
            limit_hit = ($signed(value) > $signed(limit));
         end
      end
   endfunction

   thic_i2c_target #(
      .DEV_ADDR (DEV_ADDR)
   ) u_target (
      .ref_clk_i   (ref_clk_i),
      .rstn_i      (rstn_i),
      .scl_i       (scl_i),
      .sda_i       (sda_i),
      .sda_o       (sda_o),
      .sda_oe_o    (sda_oe_o),
      .rdata_i     (rdata),
      .addr_o      (reg_addr),
      .wdata_o     (reg_wdata),
      .wr_stb_o    (reg_wr),
      .addressed_o (addressed),
      .busy_o      (bus_busy)
   );

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         planar_first_limit_code_ff  <= `THIC_RST_VAL;
         planar_second_limit_code_ff <= `THIC_RST_VAL;
         vertical_limit_code_ff      <= `THIC_RST_VAL;
         temperature_setup_ff        <= `THIC_RST_VAL;
         alert_setup_ff              <= `THIC_RST_VAL;
         gain_correction_reg_ff      <= `THIC_RST_VAL;
      end else if (reg_wr) begin
         case (reg_addr)
            `THIC_OFF_PLANAR1: planar_first_limit_code_ff <= reg_wdata; // RQ1
            `THIC_OFF_PLANAR2: planar_second_limit_code_ff <= reg_wdata; // RQ2
            `THIC_OFF_VERT:    vertical_limit_code_ff <= reg_wdata; // RQ3
            `THIC_OFF_TEMP:    temperature_setup_ff <= reg_wdata; // RQ6
            `THIC_OFF_ALERT:   alert_setup_ff <= reg_wdata & `THIC_ALERT_WMASK;
            `THIC_OFF_GAIN:    gain_correction_reg_ff <= reg_wdata; // RQ13
            default: begin
            end
         endcase
      end
   end

   always @* begin
      case (reg_addr)
         `THIC_OFF_PLANAR1: rdata = planar_first_limit_code_ff;
         `THIC_OFF_PLANAR2: rdata = planar_second_limit_code_ff;
         `THIC_OFF_VERT:    rdata = vertical_limit_code_ff;
         `THIC_OFF_TEMP:    rdata = temperature_setup_ff;
         `THIC_OFF_ALERT:   rdata = alert_setup_ff;
         `THIC_OFF_GAIN:    rdata = gain_correction_reg_ff;
         default:           rdata = 8'h00;
      endcase
   end

   // Results arrive already scaled by the span bits, so the raw code
   // matches the step of base scale times (1 + span) over 128.
   wire dir_below = limit_direction_i &
                    (hysteresis_i <= `THIC_HYST_DIR_MAX); // RQ16
   wire hit_first  = limit_hit(planar_first_msb_i,
                               planar_first_limit_code_ff, dir_below); // RQ4
   wire hit_second = limit_hit(planar_second_msb_i,
                               planar_second_limit_code_ff, dir_below); // RQ18
   wire hit_vert   = limit_hit(vertical_msb_i,
                               vertical_limit_code_ff, dir_below); // RQ5
   wire hit_temp   = (temperature_limit_code != 7'h00) &&
                     (temperature_code_i > temperature_limit_code); // RQ6
   wire any_hit    = hit_first | hit_second | hit_vert | hit_temp;

   always @* begin
      nxt_cross_cnt = cross_cnt_ff;
      limit_fire    = 1'b0;
      if (conv_done_i && any_hit) begin
         if (!crossing_count_select_i || cross_cnt_ff == 2'h3) begin
            limit_fire    = 1'b1; // RQ15
            nxt_cross_cnt = 2'h0;
         end else begin
            nxt_cross_cnt = cross_cnt_ff + 2'h1;
         end
      end
   end

   wire alert_event = conv_done_i &
                      (done_alert_on | // RQ8
                       (limit_alert_on & limit_fire)); // RQ9

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cross_cnt_ff <= 2'h0;
         latched_ff   <= 1'b0;
         pulse_cnt_ff <= 16'h0000;
      end else begin
         cross_cnt_ff <= nxt_cross_cnt;
         // A new event in the clearing cycle keeps the latch set.
         if (alert_event && !pulse_mode) begin
            latched_ff <= 1'b1; // RQ10
         end else if (addressed || pulse_mode) begin
            latched_ff <= 1'b0;
         end
         if (alert_event && pulse_mode) begin
            pulse_cnt_ff <= PULSE_CYC[15:0]; // RQ19
         end else if (pulse_cnt_ff != 16'h0000) begin
            pulse_cnt_ff <= pulse_cnt_ff - 16'h0001;
         end
      end
   end

   wire alert_lvl = pulse_mode ? (pulse_cnt_ff != 16'h0000) : latched_ff;

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_oe_ff  <= 1'b0;
         scl_drv_ff <= 1'b0;
      end else begin
         pin_oe_ff  <= 1'b0;
         scl_drv_ff <= 1'b0;
         case (route)
            `THIC_ROUTE_PIN: pin_oe_ff <= alert_lvl & ~alert_pin_disable;
            `THIC_ROUTE_PIN_NB: pin_oe_ff <= alert_lvl & ~bus_busy &
                                             ~alert_pin_disable; // RQ11
            `THIC_ROUTE_SCL: scl_drv_ff <= alert_lvl;
            `THIC_ROUTE_SCL_NB: scl_drv_ff <= alert_lvl & ~bus_busy; // RQ11
            default: begin
            end
         endcase
      end
   end

   // Trigger from a falling pin, ignored while masked or self-driven.
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pin_sync_ff <= 3'h7;
         trig_ff     <= 1'b0;
      end else begin
         pin_sync_ff <= {pin_sync_ff[1:0], alert_pin_i};
         trig_ff     <= ~pin_sync_ff[1] & pin_sync_ff[2] &
                        ~alert_pin_disable & ~pin_oe_ff; // RQ12
      end
   end

   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         gain_factor_ff <= `THIC_UNITY_GAIN;
         gain_axis_ff   <= 2'h0;
      end else begin
         gain_factor_ff <= (gain_correction_reg_ff == 8'h00) ?
                           `THIC_UNITY_GAIN :
                           {1'b0, gain_correction_reg_ff}; // RQ13
         case (angle_pair_i) // RQ14
            2'h1: gain_axis_ff <= gain_axis_pick_i ? 2'h2 : 2'h1; // RQ17
            2'h2: gain_axis_ff <= gain_axis_pick_i ? 2'h3 : 2'h2;
            2'h3: gain_axis_ff <= gain_axis_pick_i ? 2'h3 : 2'h1;
            default: gain_axis_ff <= 2'h0;
         endcase
      end
   end

   assign scl_o            = 1'b0;
   assign scl_oe_o         = scl_drv_ff;
   assign alert_pin_o      = 1'b0;
   assign alert_pin_oe_o   = pin_oe_ff;
   assign pin_trigger_o    = trig_ff;
   assign temperature_acquire_on_o =
      temperature_setup_ff[`THIC_TEMP_ACQ_BIT]; // RQ7
   assign gain_factor_o    = gain_factor_ff;
   assign gain_axis_o      = gain_axis_ff;
   assign alert_o          = alert_lvl;
endmodule

// [sim/thic_limit_alert_asserts.sv]
// Checker for the limit and alert block, bound to its top module.
// Assumes the top module's port names and its pulse length parameter.
`timescale 1ns/1ps
module thic_limit_alert_chk #(
   parameter PULSE_CYC = 400
) (
   input wire       ref_clk_i,
   input wire       rstn_i,
   input wire       scl_oe_o,
   input wire       alert_pin_oe_o,
   input wire       pin_trigger_o,
   input wire [1:0] angle_pair_i,
   input wire       gain_axis_pick_i,
   input wire [8:0] gain_factor_o,
   input wire [1:0] gain_axis_o,
   input wire       conv_done_i,
   input wire       alert_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   reg  [15:0] hi_cnt_ff;
   wire [1:0]  axis = (angle_pair_i == 2'h0) ? 2'h0 :
      gain_axis_pick_i ? ((angle_pair_i == 2'h1) ? 2'h2 : 2'h3) :
      ((angle_pair_i == 2'h2) ? 2'h2 : 2'h1);
   // Counts how long the alert has been high, for the pulse length check.
   always @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i)
         hi_cnt_ff <= 16'h0000;
      else if (alert_o)
         hi_cnt_ff <= hi_cnt_ff + 16'h0001;
      else
         hi_cnt_ff <= 16'h0000;
   end
   property p_gain_range;
      gain_factor_o != 9'h000 && gain_factor_o <= 9'h100;
   endproperty
   a_gain_range: assert property (p_gain_range)
      else $error("gain factor out of range");
   property p_gain_axis;
      $past(rstn_i) && $stable(angle_pair_i) && $stable(gain_axis_pick_i)
         |-> gain_axis_o == axis;
   endproperty
   a_gain_axis: assert property (p_gain_axis)
      else $error("gain axis does not match selection");
   property p_alert_cause;
      $rose(alert_o) |-> $past(conv_done_i);
   endproperty
   a_alert_cause: assert property (p_alert_cause)
      else $error("alert rose without a conversion");
   property p_pulse_len;
      $fell(alert_o) |-> hi_cnt_ff >= PULSE_CYC;
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("alert ended too early");
   property p_pin_src;
      alert_pin_oe_o |-> $past(alert_o);
   endproperty
   a_pin_src: assert property (p_pin_src)
      else $error("pin driven without alert");
   property p_scl_src;
      scl_oe_o |-> $past(alert_o);
   endproperty
   a_scl_src: assert property (p_scl_src)
      else $error("clock line driven without alert");
   property p_one_route;
      !(alert_pin_oe_o && scl_oe_o);
   endproperty
   a_one_route: assert property (p_one_route)
      else $error("alert driven on both routes");
   property p_trig_pulse;
      pin_trigger_o |=> !pin_trigger_o;
   endproperty
   a_trig_pulse: assert property (p_trig_pulse)
      else $error("trigger pulse longer than one cycle");
endmodule
bind thic_limit_alert thic_limit_alert_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (
   .ref_clk_i, .rstn_i, .scl_oe_o, .alert_pin_oe_o, .pin_trigger_o,
   .angle_pair_i, .gain_axis_pick_i, .gain_factor_o, .gain_axis_o,
   .conv_done_i, .alert_o
);

// [sim/thic_host.sv]
// Bus host model: drives clock and data lines open-drain, 200 ns bits.
// Assumes the bench resolves the lines with pull-ups.
`timescale 1ns/1ps
module thic_host #(
   parameter [6:0] DEV_ADDR = 7'h35
) (
   input  wire sda_i,
   output reg  scl_oe_o,
   output reg  sda_oe_o
);
   reg [7:0] rd_byte;
   reg       rd_ack;
   initial begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end
   // Data changes while the clock is low and is sampled at the end of high.
   task bit_x(input b, output r);
      begin
         #25 sda_oe_o = ~b;
         #75 scl_oe_o = 1'b0;
         #100 r = sda_i;
         scl_oe_o = 1'b1;
      end
   endtask
   task byte_x(input [7:0] d, input last);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1)
            bit_x(d[i], rd_byte[i]);
         bit_x(last, rd_ack);
      end
   endtask
   task start;
      begin
         sda_oe_o = 1'b0;
         #50 scl_oe_o = 1'b0;
         #100 sda_oe_o = 1'b1;
         #100 scl_oe_o = 1'b1;
      end
   endtask
   task stop;
      begin
         #25 sda_oe_o = 1'b1;
         #75 scl_oe_o = 1'b0;
         #100 sda_oe_o = 1'b0;
         #100;
      end
   endtask
   task wr(input [7:0] off, input [7:0] d);
      begin
         start;
         byte_x({DEV_ADDR, 1'b0}, 1'b1);
         byte_x(off, 1'b1);
         byte_x(d, 1'b1);
         stop;
      end
   endtask
   task rd(input [7:0] off, output [7:0] q);
      begin
         start;
         byte_x({DEV_ADDR, 1'b0}, 1'b1);
         byte_x(off, 1'b1);
         start;
         byte_x({DEV_ADDR, 1'b1}, 1'b1);
         byte_x(8'hFF, 1'b1);
         q = rd_byte;
         stop;
      end
   endtask
endmodule

// [sim/thic_limit_alert_tb.sv]
// Bench for the limit and alert block, driven through the bus host model.
// Assumes open-drain lines with pull-ups, resolved here.
`timescale 1ns/1ps
module thic_limit_alert_tb;
   localparam        PCYC = 8;
   localparam [47:0] WV   = 48'h817F0135FF40;
   localparam [15:0] AX   = 16'hDE90;
   reg        clk, rstn, conv_done, cnt_sel, dir, pick, pin_pull;
   reg  [7:0] p1, q;
   reg  [6:0] tcode;
   reg  [2:0] hyst;
   reg  [1:0] pair;
   wire       scl_oe, sda_oe, pin_oe, h_scl, h_sda, trig, tacq, alert;
   wire [8:0] gfac;
   wire [1:0] gax;
   wire       scl = ~(scl_oe | h_scl);
   wire       sda = ~(sda_oe | h_sda);
   wire       pin = ~(pin_oe | pin_pull);
   integer    err_total, tests_run, i, hi_n, pin_n, scl_n, trig_n;
   thic_limit_alert #(.PULSE_CYC(PCYC)) u_dut (
      .ref_clk_i(clk), .rstn_i(rstn),
      .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
      .alert_pin_i(pin), .alert_pin_o(), .alert_pin_oe_o(pin_oe),
      .conv_done_i(conv_done), .planar_first_msb_i(p1),
      .planar_second_msb_i(p1), .vertical_msb_i(p1),
      .temperature_code_i(tcode), .crossing_count_select_i(cnt_sel),
      .limit_direction_i(dir), .hysteresis_i(hyst),
      .gain_axis_pick_i(pick), .angle_pair_i(pair),
      .temperature_acquire_on_o(tacq), .pin_trigger_o(trig),
      .gain_factor_o(gfac), .gain_axis_o(gax), .alert_o(alert)
   );
   thic_host u_host (.sda_i(sda), .scl_oe_o(h_scl), .sda_oe_o(h_sda));
   initial clk = 1'b0;
   always #12.5 clk = ~clk;
   task chk(input [8:0] got, input [8:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // Fires one conversion and counts alert and drive cycles after it.
   task conv;
      begin
         @(negedge clk) conv_done = 1'b1;
         hi_n = 0;
         pin_n = 0;
         scl_n = 0;
         repeat (20) begin
            @(negedge clk) conv_done = 1'b0;
            hi_n = hi_n + alert;
            pin_n = pin_n + pin_oe;
            scl_n = scl_n + scl_oe;
         end
      end
   endtask
   task pull;
      begin
         @(negedge clk) pin_pull = 1'b1;
         trig_n = 0;
         repeat (10) @(negedge clk) trig_n = trig_n + trig;
         pin_pull = 1'b0;
         repeat (4) @(negedge clk);
      end
   endtask
   task lim(input [7:0] off, input [7:0] lv, input [7:0] val,
            input [3:0] dh, input e);
      begin
         u_host.wr(off, lv);
         @(negedge clk) {dir, hyst, p1, tcode} = {dh, val, val[6:0]};
         conv;
         chk(hi_n, e ? PCYC : 0);
         u_host.wr(off, 8'h00);
      end
   endtask
   initial begin
      #2000000;
      err_total = err_total + 1;
      end_of_test;
   end
   initial begin
      {rstn, conv_done, cnt_sel, dir, pick, pin_pull} = 6'h00;
      {p1, tcode, hyst, pair} = 20'h00000;
      err_total = 0;
      tests_run = 0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk(gfac, 9'h100);
      chk(tacq, 1'b0);
      for (i = 4; i < 10; i = i + 1) begin
         u_host.rd(i[7:0], q);
         chk(q, 8'h00);
      end
      for (i = 0; i < 6; i = i + 1) begin
         u_host.wr(i[7:0] + 8'h04, WV[47 - 8 * i -: 8]);
         u_host.rd(i[7:0] + 8'h04, q);
         chk(q, WV[47 - 8 * i -: 8] & ((i == 4) ? 8'hFD : 8'hFF));
      end
      chk(tacq, 1'b1);
      chk(gfac, 9'h040);
      u_host.wr(8'h03, 8'hAA);
      u_host.rd(8'h03, q);
      chk(q, 8'h00);
      u_host.wr(8'h09, 8'h00);
      chk(gfac, 9'h100);
      for (i = 0; i < 8; i = i + 1) begin
         @(negedge clk) {pair, pick} = i[2:0];
         repeat (2) @(negedge clk);
         chk(gax, AX[2 * i +: 2]);
      end
      for (i = 0; i < 8; i = i + 1) begin
         u_host.wr(8'h08, {3'h5, i[2:0], 2'h0});
         conv;
         chk(hi_n, PCYC);
         chk(pin_n, (i == 1 || i == 2) ? PCYC : 0);
         chk(scl_n, (i == 3 || i == 4) ? PCYC : 0);
      end
      u_host.wr(8'h08, 8'h84);
      conv;
      chk(hi_n, 20);
      chk(pin_n, 19);
      u_host.start;
      u_host.byte_x({7'h36, 1'b0}, 1'b1);
      u_host.stop;
      chk(u_host.rd_ack, 1'b1);
      chk(alert, 1'b1);
      u_host.rd(8'h08, q);
      chk(alert, 1'b0);
      chk(pin_oe, 1'b0);
      u_host.wr(8'h08, 8'hA5);
      conv;
      chk(pin_n, 0);
      u_host.wr(8'h08, 8'h24);
      conv;
      chk(hi_n, 0);
      pull;
      chk(trig_n, 1);
      u_host.wr(8'h08, 8'h25);
      pull;
      chk(trig_n, 0);
      u_host.wr(8'h08, 8'hA8);
      fork
         u_host.wr(8'h09, 8'h40);
         begin
            #3000;
            conv;
         end
      join
      chk(hi_n, PCYC);
      chk(pin_n, 0);
      u_host.wr(8'h08, 8'h64);
      for (i = 4; i < 8; i = i + 1)
         u_host.wr(i[7:0], 8'h00);
      lim(8'h04, 8'h10, 8'h20, 4'h0, 1'b1);
      lim(8'h04, 8'h10, 8'h05, 4'h0, 1'b0);
      lim(8'h05, 8'hF0, 8'hF8, 4'h0, 1'b1);
      lim(8'h06, 8'h01, 8'h80, 4'h0, 1'b0);
      lim(8'h06, 8'h01, 8'h7F, 4'h0, 1'b1);
      lim(8'h07, 8'h35, 8'h20, 4'h0, 1'b1);
      lim(8'h07, 8'h35, 8'h10, 4'h0, 1'b0);
      lim(8'h04, 8'h00, 8'h7F, 4'h0, 1'b0);
      lim(8'h04, 8'h10, 8'h05, 4'h8, 1'b1);
      lim(8'h04, 8'h10, 8'h05, 4'hA, 1'b0);
      u_host.wr(8'h04, 8'h10);
      @(negedge clk) {cnt_sel, dir, hyst, p1} = 13'h1020;
      for (i = 0; i < 4; i = i + 1) begin
         conv;
         chk(hi_n, (i == 3) ? PCYC : 0);
      end
      end_of_test;
   end
endmodule
